// file: hw/peripheral_soft_reset_ctl.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// software reset control for peripheral units, behind an ahb-lite slave
module peripheral_soft_reset_ctl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // ahb-lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // presence of units, from the capability registers
  input  wire logic [31:0] capMaskTwo,
  input  wire logic [31:0] capMaskFour,
  // unit resets, high holds the unit in reset
  output logic [1:0]       analogCompReset,
  output logic [3:0]       gpCounterReset,
  output logic [1:0]       twowireReset,
  output logic [1:0]       syncSerialReset,
  output logic [2:0]       asyncSerialReset,
  output logic             usbUnitReset,
  output logic             microDmaReset,
  output logic [7:0]       ioPortReset
);
  // pending data phase and read data
  typedef struct packed {
    logic                    wrPend;  // write data phase follows
    soft_reset_pkg::reg_sel_t wrSel;  // register of that write
    logic [31:0]             rdData;  // read data for the data phase
  } bus_state_t;

  bus_state_t state_r;    // registered bus state
  bus_state_t state_nxt;  // next bus state
  logic       accept;     // valid word transfer taken this cycle
  soft_reset_pkg::reg_sel_t addrSel;  // register addressed now

  reset_bank_if bankOne ();  // first reset register
  reset_bank_if bankTwo ();  // second reset register

  // address decode, used by both read and write paths
  function automatic soft_reset_pkg::reg_sel_t regSelect(input logic [31:0] addr);
    if (addr == soft_reset_pkg::CTL_BASE + soft_reset_pkg::OFFS_RESET_ONE) begin
      return soft_reset_pkg::SEL_ONE;
    end else if (addr == soft_reset_pkg::CTL_BASE + soft_reset_pkg::OFFS_RESET_TWO) begin
      return soft_reset_pkg::SEL_TWO;
    end else begin
      return soft_reset_pkg::SEL_NONE;
    end
  endfunction

  // only whole-word transfers are served; others complete with no effect
  assign accept  = hsel && hready && (htrans == soft_reset_pkg::HTRANS_NONSEQ)
                   && (hsize == soft_reset_pkg::HSIZE_WORD);
  assign addrSel = regSelect(haddr);

  // write commits in the data phase, when hwdata is valid
  // first register gated by capability two
  assign bankOne.wrEn    = state_r.wrPend && hready
                           && (state_r.wrSel == soft_reset_pkg::SEL_ONE);
  assign bankOne.wrData  = hwdata;
  assign bankOne.capMask = capMaskTwo;
  // second register gated by capability four
  assign bankTwo.wrEn    = state_r.wrPend && hready
                           && (state_r.wrSel == soft_reset_pkg::SEL_TWO);
  assign bankTwo.wrData  = hwdata;
  assign bankTwo.capMask = capMaskFour;

  // the two banks; reserved bits are never stored
  reset_bit_bank #(
    .WIDTH     (32),
    .IMPL_MASK (soft_reset_pkg::IMPL_ONE)
  ) u_bank_one (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .port    (bankOne.bank)
  );

  reset_bit_bank #(
    .WIDTH     (32),
    .IMPL_MASK (soft_reset_pkg::IMPL_TWO)
  ) u_bank_two (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .port    (bankTwo.bank)
  );

  // bus next state
  always_comb begin
    state_nxt = state_r;
    if (hready) begin
      state_nxt.wrPend = accept && hwrite;
      state_nxt.wrSel  = accept ? addrSel : soft_reset_pkg::SEL_NONE;
      // read takes the post-commit value so a write just before is seen
      if (accept && !hwrite && addrSel == soft_reset_pkg::SEL_ONE) begin
        state_nxt.rdData = bankOne.valueNxt;
      end else if (accept && !hwrite && addrSel == soft_reset_pkg::SEL_TWO) begin
        state_nxt.rdData = bankTwo.valueNxt;
      end else begin
        // unmapped or idle reads as zero
        state_nxt.rdData = 32'h00000000;
      end
    end
  end

  // bus state register, frozen while the clock enable is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // zero wait states; a frozen block stretches the transfer instead
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = state_r.rdData;

  // unit resets straight from the bank flops
  // bit high holds unit
  assign analogCompReset  = bankOne.value[soft_reset_pkg::ONE_COMP_LSB +: 2];
  assign gpCounterReset   = bankOne.value[soft_reset_pkg::ONE_COUNTER_LSB +: 4];
  assign twowireReset     = {bankOne.value[soft_reset_pkg::ONE_TWOWIRE1],
                             bankOne.value[soft_reset_pkg::ONE_TWOWIRE0]};
  assign syncSerialReset  = bankOne.value[soft_reset_pkg::ONE_SYNC_LSB +: 2];
  assign asyncSerialReset = bankOne.value[soft_reset_pkg::ONE_ASYNC_LSB +: 3];
  assign usbUnitReset     = bankTwo.value[soft_reset_pkg::TWO_USB_BIT];
  assign microDmaReset    = bankTwo.value[soft_reset_pkg::TWO_DMA_BIT];
  assign ioPortReset      = bankTwo.value[soft_reset_pkg::TWO_PORT_LSB +: 8];

  // effective write masks, helpers for the checks below
  logic [31:0] effOne;  // writable bits of the first register
  logic [31:0] effTwo;  // writable bits of the second register
  assign effOne = capMaskTwo & soft_reset_pkg::IMPL_ONE;
  assign effTwo = capMaskFour & soft_reset_pkg::IMPL_TWO;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // masked write lands one edge after the data phase
  a_mask_write_one: assert property (
    (ce && bankOne.wrEn) |=> bankOne.value ==
      (($past(bankOne.value) & ~$past(effOne)) | ($past(hwdata) & $past(effOne))))
    else $error("first register write not masked correctly");

  a_mask_write_two: assert property (
    (ce && bankTwo.wrEn) |=> bankTwo.value ==
      (($past(bankTwo.value) & ~$past(effTwo)) | ($past(hwdata) & $past(effTwo))))
    else $error("second register write not masked correctly");

  // both registers clear after reset, until a write arrives
  a_reset_clears: assert property (
    $fell(rst) |-> (bankOne.value == soft_reset_pkg::RESET_VALUE)
      && (bankTwo.value == soft_reset_pkg::RESET_VALUE))
    else $error("reset registers not zero after reset");

  // comparator resets move only through a first register write
  a_comp_stable: assert property (
    !(ce && bankOne.wrEn) |=> $stable(analogCompReset))
    else $error("comparator reset changed without a write");

  // readback of a first register read matches the counter resets
  a_counter_readback: assert property (
    (ce && accept && !hwrite && addrSel == soft_reset_pkg::SEL_ONE)
      |=> hrdata[19:16] == gpCounterReset)
    else $error("counter reset readback mismatch");

  // two-wire resets and their reserved neighbours read back
  a_twowire_readback: assert property (
    (ce && accept && !hwrite && addrSel == soft_reset_pkg::SEL_ONE)
      |=> (hrdata[14] == twowireReset[1]) && (hrdata[12] == twowireReset[0])
        && (hrdata[15] == 1'b0) && (hrdata[13] == 1'b0))
    else $error("two-wire reset readback mismatch");

  a_serial_readback: assert property (
    (ce && accept && !hwrite && addrSel == soft_reset_pkg::SEL_ONE)
      |=> (hrdata[5:4] == syncSerialReset) && (hrdata[11:6] == 6'h00))
    else $error("sync serial reset readback mismatch");

  a_async_readback: assert property (
    (ce && accept && !hwrite && addrSel == soft_reset_pkg::SEL_ONE)
      |=> (hrdata[2:0] == asyncSerialReset) && (hrdata[3] == 1'b0))
    else $error("async serial reset readback mismatch");

  // reserved bits never hold ones
  a_rsvd_one_zero: assert property (
    (bankOne.value & ~soft_reset_pkg::IMPL_ONE) == 32'h00000000)
    else $error("first register reserved bit set");

  a_rsvd_two_high: assert property (
    (bankTwo.value[31:17] == 15'h0000) && (bankTwo.value[15:14] == 2'h0))
    else $error("second register upper reserved bit set");

  a_rsvd_two_mid: assert property (
    bankTwo.value[12:8] == 5'h00)
    else $error("second register middle reserved bit set");

  // port 0 reset follows a present-unit write of one, over two cycles
  a_port_set: assert property (
    (ce && bankTwo.wrEn && hwdata[0] && capMaskFour[0]) ##1 ce
      |-> ioPortReset[0] ##1 (ioPortReset[0] || $past(bankTwo.wrEn)))
    else $error("io port reset not asserted after write");

  // clearing a bit releases its unit on the next edge
  a_release_unit: assert property (
    (ce && bankTwo.wrEn && !hwdata[soft_reset_pkg::TWO_DMA_BIT]
      && capMaskFour[soft_reset_pkg::TWO_DMA_BIT])
      |=> !microDmaReset)
    else $error("dma unit not released after clear");

  // bits of absent units never move on a write
  a_absent_hold: assert property (
    (ce && bankOne.wrEn) |=> ((bankOne.value ^ $past(bankOne.value)) & ~$past(effOne))
      == 32'h00000000)
    else $error("absent unit bit changed on write");

  c_write_one: cover property (ce && bankOne.wrEn && (hwdata & effOne) != 32'h00000000);
  c_write_two: cover property (ce && bankTwo.wrEn && (hwdata & effTwo) != 32'h00000000);
  c_read_two:  cover property (ce && accept && !hwrite && addrSel == soft_reset_pkg::SEL_TWO);
  c_unmapped:  cover property (ce && accept && addrSel == soft_reset_pkg::SEL_NONE);
  c_stall:     cover property (!ce && hsel && htrans == soft_reset_pkg::HTRANS_NONSEQ);
endmodule // peripheral_soft_reset_ctl
`default_nettype wire

// file: include/soft_reset_pkg.sv
`default_nettype none
package soft_reset_pkg;
  // register window of the system control space
  localparam logic [31:0] CTL_BASE        = 32'h400FE000;
  localparam logic [31:0] OFFS_RESET_ONE  = 32'h00000044;
  localparam logic [31:0] OFFS_RESET_TWO  = 32'h00000048;
  localparam logic [31:0] RESET_VALUE     = 32'h00000000;
  // bits that exist in each register; the rest are reserved zeros
  localparam logic [31:0] IMPL_ONE        = 32'h030F5037;
  localparam logic [31:0] IMPL_TWO        = 32'h000120FF;
  // field positions, first register
  localparam int unsigned ONE_COMP_LSB    = 24;
  localparam int unsigned ONE_COUNTER_LSB = 16;
  localparam int unsigned ONE_TWOWIRE1    = 14;
  localparam int unsigned ONE_TWOWIRE0    = 12;
  localparam int unsigned ONE_SYNC_LSB    = 4;
  localparam int unsigned ONE_ASYNC_LSB   = 0;
  // field positions, second register
  localparam int unsigned TWO_USB_BIT     = 16;
  localparam int unsigned TWO_DMA_BIT     = 13;
  localparam int unsigned TWO_PORT_LSB    = 0;
  // bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  // which register an access selects
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_ONE  = 2'b01,
    SEL_TWO  = 2'b10
  } reg_sel_t;
endpackage
`default_nettype wire

// file: include/reset_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
// write port and readback of one reset register bank
interface reset_bank_if;
  logic        wrEn;      // one-cycle commit strobe
  logic [31:0] wrData;    // raw data from software
  logic [31:0] capMask;   // units present in this device
  logic [31:0] value;     // registered bank contents
  logic [31:0] valueNxt;  // contents after this cycle's commit
  modport ctl  (output wrEn, output wrData, output capMask, input value, input valueNxt);
  modport bank (input wrEn, input wrData, input capMask, output value, output valueNxt);
endinterface
`default_nettype wire

// file: hw/reset_bit_bank.sv
`timescale 1ns/1ps
`default_nettype none
// one register of per-unit reset bits with masked writes
module reset_bit_bank #(
  parameter int unsigned WIDTH     = 32,
  parameter logic [31:0] IMPL_MASK = 32'h00000000
) (
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire logic     ce,
  reset_bank_if.bank    port
);
  // whole state of the bank
  typedef struct packed {
    logic [31:0] value;
  } bank_state_t;

  bank_state_t state_r;    // registered bank
  bank_state_t state_nxt;  // next bank
  logic [31:0] bitNxt;     // per-bit next values

  // refuse widths the 32-bit bus cannot carry
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("reset_bit_bank: WIDTH must be 1..32");
  end

  // per-bit update: a bit moves only if it exists and its unit is present
  for (genvar i = 0; i < 32; i++) begin : g_bit
    if (i < WIDTH && IMPL_MASK[i]) begin : g_live
      assign bitNxt[i] = (port.wrEn && port.capMask[i]) ? port.wrData[i] : state_r.value[i];
    end else begin : g_rsvd
      assign bitNxt[i] = 1'b0;
    end
  end

  // next state
  always_comb begin
    state_nxt       = state_r;
    state_nxt.value = bitNxt;
  end

  // clears on reset; clock enable freezes the bank
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign port.value    = state_r.value;
  assign port.valueNxt = bitNxt;
endmodule // reset_bit_bank
`default_nettype wire

// file: testbench/peripheral_soft_reset_ctl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// register-level bench for the peripheral software reset block
module peripheral_soft_reset_ctl_bench;
  // writable bits of each register, taken from the bit tables
  localparam logic [31:0] WR_ONE = 32'h030F5037;
  localparam logic [31:0] WR_TWO = 32'h000120FF;
  localparam logic [31:0] A_ONE  = soft_reset_pkg::CTL_BASE + soft_reset_pkg::OFFS_RESET_ONE;
  localparam logic [31:0] A_TWO  = soft_reset_pkg::CTL_BASE + soft_reset_pkg::OFFS_RESET_TWO;
  localparam logic [2:0]  WORD   = soft_reset_pkg::HSIZE_WORD;

  logic        sys_clk;           // 50 MHz system clock
  logic        rst;               // async reset, high
  logic        ce;                // clock enable
  logic        hsel;              // slave select
  logic [31:0] haddr;             // byte address
  logic [1:0]  htrans;            // transfer kind
  logic        hwrite;            // write when high
  logic [2:0]  hsize;             // transfer size
  logic [31:0] hwdata;            // write data
  logic        hreadyout;         // slave ready, fed back as hready
  logic        hresp;             // response code
  logic [31:0] hrdata;            // read data
  logic [31:0] capMaskTwo;        // presence mask, first register
  logic [31:0] capMaskFour;       // presence mask, second register
  logic [1:0]  analogCompReset;   // comparator resets
  logic [3:0]  gpCounterReset;    // counter resets
  logic [1:0]  twowireReset;      // two-wire resets
  logic [1:0]  syncSerialReset;   // sync serial resets
  logic [2:0]  asyncSerialReset;  // async serial resets
  logic        usbUnitReset;      // usb reset
  logic        microDmaReset;     // dma reset
  logic [7:0]  ioPortReset;       // io port resets
  logic [31:0] outOne;            // unit resets laid out as first register
  logic [31:0] outTwo;            // unit resets laid out as second register
  int          mismatches;        // failed comparisons
  int          checkCount;        // all comparisons

  // regroup the unit outputs at their register bit positions
  assign outOne = {6'h00, analogCompReset, 4'h0, gpCounterReset, 1'b0, twowireReset[1], 1'b0,
                   twowireReset[0], 6'h00, syncSerialReset, 1'b0, asyncSerialReset};
  assign outTwo = {15'h0000, usbUnitReset, 2'h0, microDmaReset, 5'h00, ioPortReset};

  peripheral_soft_reset_ctl peripheral_soft_reset_ctl_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capMaskTwo(capMaskTwo),
    .capMaskFour(capMaskFour), .analogCompReset(analogCompReset),
    .gpCounterReset(gpCounterReset), .twowireReset(twowireReset),
    .syncSerialReset(syncSerialReset), .asyncSerialReset(asyncSerialReset),
    .usbUnitReset(usbUnitReset), .microDmaReset(microDmaReset), .ioPortReset(ioPortReset)
  );

  // free-running clock, 20 ns period
  always #10 sys_clk = ~sys_clk;

  // compare and count, report at once
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single transfer; waits on hready, so no cycle count is assumed
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= soft_reset_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= sz;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    // taken before this edge's updates land
    rd = hrdata;
  endtask

  // word write, read data discarded
  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    xfer(1'b1, addr, wd, WORD, rd);
  endtask

  // read both registers and compare readback and unit outputs
  task automatic chkRegs(input logic [31:0] e1, input logic [31:0] e2, input string what);
    logic [31:0] rd;
    xfer(1'b0, A_ONE, 32'h00000000, WORD, rd);
    check({what, " first readback"}, rd, e1);
    check({what, " first outputs"}, outOne, e1);
    xfer(1'b0, A_TWO, 32'h00000000, WORD, rd);
    check({what, " second readback"}, rd, e2);
    check({what, " second outputs"}, outTwo, e2);
  endtask

  // print counts and verdict, end the run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(20 * 5000);
    mismatches++;
    summarize();
  end

  // main sequence
  initial begin
    logic [31:0] rd;    // read data of single checks
    logic [31:0] walk;  // walking-one pattern
    sys_clk     = 1'b0;
    rst         = 1'b1;
    ce          = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h00000000;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = WORD;
    hwdata      = 32'h00000000;
    capMaskTwo  = 32'hFFFFFFFF;
    capMaskFour = 32'hFFFFFFFF;
    mismatches  = 0;
    checkCount  = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chkRegs(32'h00000000, 32'h00000000, "after reset");
    // walking one through every bit, reserved ones stay zero
    for (int i = 0; i < 32; i++) begin
      walk = 32'h00000001 << i;
      wr(A_ONE, walk);
      wr(A_TWO, walk);
      chkRegs(walk & WR_ONE, walk & WR_TWO, "walking bit");
    end
    // all ones, read straight after write, then release
    wr(A_ONE, 32'hFFFFFFFF);
    wr(A_TWO, 32'hFFFFFFFF);
    chkRegs(WR_ONE, WR_TWO, "all ones");
    wr(A_ONE, 32'h00000000);
    wr(A_TWO, 32'h00000000);
    chkRegs(32'h00000000, 32'h00000000, "release");
    // partial capability masks
    capMaskTwo  <= 32'h02055001;
    capMaskFour <= 32'h00010081;
    wr(A_ONE, 32'hFFFFFFFF);
    wr(A_TWO, 32'hFFFFFFFF);
    chkRegs(WR_ONE & 32'h02055001, WR_TWO & 32'h00010081, "masked write");
    // masks cleared: writes of zero must not reach the bits
    capMaskTwo  <= 32'h00000000;
    capMaskFour <= 32'h00000000;
    wr(A_ONE, 32'h00000000);
    wr(A_TWO, 32'h00000000);
    chkRegs(WR_ONE & 32'h02055001, WR_TWO & 32'h00010081, "mask off");
    capMaskTwo  <= 32'hFFFFFFFF;
    capMaskFour <= 32'hFFFFFFFF;
    // unmapped address and halfword size leave the bits alone
    wr(A_TWO + 32'h00000004, 32'h00000000);
    xfer(1'b0, A_TWO + 32'h00000004, 32'h00000000, WORD, rd);
    check("unmapped read", rd, 32'h00000000);
    xfer(1'b1, A_ONE, 32'h00000000, 3'h1, rd);
    xfer(1'b0, A_ONE, 32'h00000000, 3'h1, rd);
    check("halfword read", rd, 32'h00000000);
    check("response", {31'h00000000, hresp}, 32'h00000000);
    chkRegs(WR_ONE & 32'h02055001, WR_TWO & 32'h00010081, "ignored");
    // enable low stretches a write until it returns
    ce <= 1'b0;
    fork
      wr(A_ONE, 32'hFFFFFFFF);
      begin
        repeat (3) @(posedge sys_clk);
        check("stall ready", {31'h00000000, hreadyout}, 32'h00000000);
        ce <= 1'b1;
      end
    join
    chkRegs(WR_ONE, WR_TWO & 32'h00010081, "stretched");
    // read-modify-write: reserved bits go back exactly as they were read
    xfer(1'b0, A_TWO, 32'h00000000, WORD, rd);
    wr(A_TWO, rd | 32'h00002000);
    chkRegs(WR_ONE, 32'h00012081, "read-modify-write");
    // reset in mid-run clears every unit reset
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset first", outOne, 32'h00000000);
    check("reset second", outTwo, 32'h00000000);
    rst <= 1'b0;
    @(posedge sys_clk);
    chkRegs(32'h00000000, 32'h00000000, "second reset");
    summarize();
  end
endmodule // peripheral_soft_reset_ctl_bench
`default_nettype wire
